// [wwdt_defines.svh]
// Purpose: constants for the windowed watchdog timer
// Assumes: 32-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH
`define WWDT_OFS_CMD 4'h0
`define WWDT_OFS_SET 4'h4
`define WWDT_OFS_FLAG 4'h8
`define WWDT_KEY 8'hA5
`define WWDT_KEY_HI 31
`define WWDT_KEY_LO 24
`define WWDT_RESTART_BIT 0
`define WWDT_RLD_HI 11
`define WWDT_RLD_LO 0
`define WWDT_FIEN_BIT 12
`define WWDT_RSTEN_BIT 13
`define WWDT_SCOPE_BIT 14
`define WWDT_DIS_BIT 15
`define WWDT_WIN_HI 27
`define WWDT_WIN_LO 16
`define WWDT_DBGH_BIT 28
`define WWDT_IDLEH_BIT 29
`define WWDT_SET_RESET 32'h3FFF2FFF
`define WWDT_UNF_BIT 0
`define WWDT_ERR_BIT 1
`define WWDT_PRESCALE 128
`define WWDT_SLOW_HZ 32768
`define WWDT_SYS_HZ 50000000
`endif

// [wwdt_pkg.sv]
// Purpose: types for the windowed watchdog timer
// Assumes: nothing
// Notes: state type for the slow tick generator
package wwdt_pkg;
  typedef enum logic [1:0] {
    WWDT_TK_IDLE = 2'b00,
    WWDT_TK_RUN = 2'b01,
    WWDT_TK_TICK = 2'b11
  } wwdt_tick_st_t;
endpackage

// [wwdt_tick_gen.sv]
// Purpose: slow clock enable and divide-by-prescale tick
// Assumes: single system clock
// Notes: clear restarts the prescaler only; the slow clock enable runs free
`timescale 1ns/1ns
`include "wwdt_defines.svh"
module wwdt_tick_gen
  import wwdt_pkg::*;
#(
  parameter int SLOW_DIV = `WWDT_SYS_HZ / `WWDT_SLOW_HZ,
  parameter int PRESCALE = `WWDT_PRESCALE
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_run,
  output logic o_slow_en,
  output logic o_tick
);
  initial begin
    // both dividers are held in fixed-width counters
    if (SLOW_DIV < 1 || SLOW_DIV > 65536 || PRESCALE < 2 || PRESCALE > 256) begin
      $error("wwdt_tick_gen: bad divider");
    end
  end
  logic [15:0] slow_cnt_reg;
  logic [7:0] pre_cnt_reg;
  wwdt_tick_st_t st_reg;
  // ==========================================
  // slow clock enable, free running so restart spacing is real time
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_cnt_reg <= 16'h0000;
    end else if (slow_cnt_reg == 16'(SLOW_DIV - 1)) begin
      slow_cnt_reg <= 16'h0000;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 16'h0001;
    end
  end
  assign o_slow_en = (slow_cnt_reg == 16'(SLOW_DIV - 1));
  // ==========================================
  // prescaler, reset on restart
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt_reg <= 8'h00;
      st_reg <= WWDT_TK_IDLE;
    end else if (i_clear) begin
      pre_cnt_reg <= 8'h00;
      st_reg <= WWDT_TK_IDLE;
    end else begin
      case (st_reg)
        WWDT_TK_IDLE: st_reg <= i_run ? WWDT_TK_RUN : WWDT_TK_IDLE;
        WWDT_TK_RUN: begin
          if (i_run && o_slow_en) begin
            if (pre_cnt_reg == 8'(PRESCALE - 1)) begin
              pre_cnt_reg <= 8'h00;
              st_reg <= WWDT_TK_TICK;
            end else begin
              pre_cnt_reg <= pre_cnt_reg + 8'h01;
            end
          end
        end
        WWDT_TK_TICK: st_reg <= WWDT_TK_RUN;
        default: st_reg <= WWDT_TK_IDLE;
      endcase
    end
  end
  assign o_tick = (st_reg == WWDT_TK_TICK) && i_run;
endmodule

// [wwdt_core.sv]
// Purpose: windowed watchdog timer with key-protected restart
// Assumes: register port strobes one cycle, read data next cycle
// Notes: fault and interrupt are levels held until status read
// How it works
// - a twelve-bit down counter loads from the programmed reload value.
// - the counter steps once per slow clock divided by 128.
// - after reset reload is 0xFFF, counter running, fault reset enabled.
// - processor reset restores register values and restarts counting.
// - an accepted (first) settings write acts as a restart with the new values.
// - only the first settings write is taken until next reset.
// - accepted restart reloads counter and clears the prescaler.
// - command writes without the correct key are ignored.
// - underflow sets its flag and raises fault when reset enabled.
// - restart above the window limit sets error flag and raises fault.
// - window limit at or above reload makes every restart legal.
// - interrupt follows either flag when fault interrupt is enabled.
// - the reset controller turns an enabled fault into a watchdog reset.
// - a reset or flag read clears flags, interrupt and fault line.
// - debug state or idle mode stop counting under their halt bits.
// - the disable bit stops counting.
// - the restart key must be 0xA5, anything else aborts the write.
// - reset scope bit selects all resets or processor reset only.
// - a halt bit at one stops the counter, at zero it runs.
`timescale 1ns/1ns
`include "wwdt_defines.svh"
module wwdt_core
  import wwdt_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int SLOW_DIV = `WWDT_SYS_HZ / `WWDT_SLOW_HZ,
  parameter int PRESCALE = `WWDT_PRESCALE
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_dbg_state,
  input wire logic i_idle_mode,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_fault,
  output logic o_fault_all_resets,
  output logic o_fault_proc_only,
  output logic [CNT_W-1:0] o_count
);
  initial begin
    if (CNT_W != 12) begin
      $error("wwdt_core: counter width must be 12");
    end
  end
  logic [31:0] set_reg;
  logic set_locked_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic unf_reg;
  logic err_reg;
  logic fault_reg;
  logic [31:0] rdata_reg;
  logic tick;
  logic slow_en;
  logic cmd_wr;
  logic set_wr;
  logic flag_rd;
  logic restart_ok;
  logic restart;
  logic window_err;
  logic halted;
  logic [CNT_W-1:0] rld_val;
  logic [CNT_W-1:0] rld_new;
  logic [CNT_W-1:0] win_val;
  logic underflow;
  // ==========================================
  // decode helpers
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction
  assign cmd_wr = i_wr && hit(i_addr, `WWDT_OFS_CMD);
  assign set_wr = i_wr && hit(i_addr, `WWDT_OFS_SET) && !set_locked_reg;
  assign flag_rd = i_rd && hit(i_addr, `WWDT_OFS_FLAG);
  // key gate on the command write
  assign restart_ok = cmd_wr && i_wdata[`WWDT_RESTART_BIT] &&
      (i_wdata[`WWDT_KEY_HI:`WWDT_KEY_LO] == `WWDT_KEY);
  assign rld_val = set_reg[`WWDT_RLD_HI:`WWDT_RLD_LO];
  assign rld_new = i_wdata[`WWDT_RLD_HI:`WWDT_RLD_LO];
  assign win_val = set_reg[`WWDT_WIN_HI:`WWDT_WIN_LO];
  // window check applies even when disabled; wide window never errs
  assign window_err = restart_ok && (cnt_reg > win_val);
  assign restart = restart_ok || set_wr;
  // ==========================================
  // halt conditions
  assign halted = set_reg[`WWDT_DIS_BIT] ||
      (set_reg[`WWDT_DBGH_BIT] && i_dbg_state) ||
      (set_reg[`WWDT_IDLEH_BIT] && i_idle_mode);
  wwdt_tick_gen #(
    .SLOW_DIV(SLOW_DIV),
    .PRESCALE(PRESCALE)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clear(restart),
    .i_run(!halted),
    .o_slow_en(slow_en),
    .o_tick(tick)
  );
  assign underflow = tick && (cnt_reg == '0) && !restart;
  // ==========================================
  // settings register, write once
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      set_reg <= `WWDT_SET_RESET;
      set_locked_reg <= 1'b0;
    end else if (set_wr) begin
      set_reg <= i_wdata;
      set_locked_reg <= 1'b1;
    end
  end
  // ==========================================
  // down counter; reload wins over a tick in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= CNT_W'(`WWDT_SET_RESET); // reload field of the reset settings
    end else if (set_wr) begin
      cnt_reg <= rld_new;
    end else if (restart_ok) begin
      cnt_reg <= rld_val;
    end else if (tick) begin
      cnt_reg <= (cnt_reg == '0) ? rld_val : cnt_reg - 12'h001;
    end
  end
  // ==========================================
  // sticky flags; a new event beats the clearing read
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unf_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      unf_reg <= underflow || (unf_reg && !flag_rd);
      err_reg <= window_err || (err_reg && !flag_rd);
    end
  end
  // fault line, level until read or reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= (underflow && set_reg[`WWDT_RSTEN_BIT]) || window_err ||
          (fault_reg && !flag_rd);
    end
  end
  assign o_fault = fault_reg;
  assign o_fault_all_resets = fault_reg && set_reg[`WWDT_RSTEN_BIT] &&
      !set_reg[`WWDT_SCOPE_BIT];
  assign o_fault_proc_only = fault_reg && set_reg[`WWDT_RSTEN_BIT] &&
      set_reg[`WWDT_SCOPE_BIT];
  assign o_irq = set_reg[`WWDT_FIEN_BIT] && (unf_reg || err_reg);
  assign o_count = cnt_reg;
  // ==========================================
  // read data, one cycle after the strobe and only then
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (i_rd && hit(i_addr, `WWDT_OFS_SET)) begin
      rdata_reg <= set_reg;
    end else if (flag_rd) begin
      rdata_reg <= {30'h00000000, err_reg, unf_reg};
    end else begin
      rdata_reg <= 32'h00000000; // command and unmapped read zero
    end
  end
  assign o_rdata = rdata_reg;
  // ==========================================
  // checks
  // tick spacing helper; halts only stretch the gap, a restart starts over
  logic [31:0] gap_reg;
  logic gap_seen_reg;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_reg <= 32'h00000000;
      gap_seen_reg <= 1'b0;
    end else if (restart) begin
      gap_reg <= 32'h00000000;
      gap_seen_reg <= 1'b0;
    end else if (tick) begin
      gap_reg <= 32'h00000000;
      gap_seen_reg <= 1'b1;
    end else if (gap_reg != 32'hFFFFFFFF) begin
      gap_reg <= gap_reg + 32'h00000001; // saturates so a long halt cannot wrap
    end
  end
  // settings lock
  lock_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      set_locked_reg && i_wr && hit(i_addr, `WWDT_OFS_SET) |=> $stable(set_reg))
    else $error("locked settings changed");
  set_once_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      set_locked_reg |=> set_locked_reg)
    else $error("settings lock dropped");
  // restart command and key
  bad_key_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      cmd_wr && i_wdata[`WWDT_KEY_HI:`WWDT_KEY_LO] != `WWDT_KEY && !set_wr && !tick
      |=> $stable(cnt_reg))
    else $error("bad key moved counter");
  restart_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      restart_ok |=> cnt_reg == $past(rld_val))
    else $error("restart did not reload");
  restart_tick_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      restart |=> !tick)
    else $error("prescaler not cleared");
  set_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      set_wr |=> cnt_reg == $past(rld_new))
    else $error("settings write did not reload");
  // counting
  count_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      cnt_reg <= rld_val)
    else $error("counter above reload");
  unf_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      underflow |=> cnt_reg == $past(rld_val))
    else $error("underflow did not reload");
  tick_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      tick && !restart && cnt_reg != '0 |=> cnt_reg == $past(cnt_reg) - 12'h001)
    else $error("tick step wrong");
  tick_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      tick && gap_seen_reg |-> gap_reg >= 32'((PRESCALE - 1) * SLOW_DIV))
    else $error("ticks too close");
  halt_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      halted && !restart |=> $stable(cnt_reg))
    else $error("halted counter moved");
  dis_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      set_reg[`WWDT_DIS_BIT] && !restart |=> $stable(cnt_reg))
    else $error("disabled counter moved");
  // faults and flags
  unf_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      underflow |=> unf_reg && (fault_reg == ($past(set_reg[`WWDT_RSTEN_BIT]) ||
      ($past(fault_reg) && !$past(flag_rd)))))
    else $error("underflow not flagged");
  win_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      restart_ok && cnt_reg > win_val |=> err_reg && fault_reg)
    else $error("window error missed");
  wide_win_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      restart_ok && win_val >= rld_val && !unf_reg && !err_reg && !underflow
      |=> !err_reg)
    else $error("wide window erred");
  fault_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(fault_reg) |-> $past(window_err) ||
      ($past(underflow) && $past(set_reg[`WWDT_RSTEN_BIT])))
    else $error("fault without cause");
  // interrupt and reset scope
  irq_map_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_irq == (set_reg[`WWDT_FIEN_BIT] && (unf_reg || err_reg)))
    else $error("interrupt mismatch");
  irq_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !set_reg[`WWDT_FIEN_BIT] |-> !o_irq)
    else $error("interrupt while masked");
  scope_all_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_fault_all_resets |-> o_fault && set_reg[`WWDT_RSTEN_BIT] && !set_reg[`WWDT_SCOPE_BIT])
    else $error("all-resets request wrong");
  scope_proc_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_fault_proc_only |-> o_fault && set_reg[`WWDT_RSTEN_BIT] && set_reg[`WWDT_SCOPE_BIT])
    else $error("processor-only request wrong");
  // levels stand until the flag read
  fault_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      fault_reg && !flag_rd |=> fault_reg)
    else $error("fault dropped early");
  unf_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      unf_reg && !flag_rd |=> unf_reg)
    else $error("underflow flag dropped");
  err_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      err_reg && !flag_rd |=> err_reg)
    else $error("error flag dropped");
  rd_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      flag_rd && !underflow && !window_err |=> !unf_reg && !err_reg && !fault_reg && !o_irq)
    else $error("read did not clear");
  rd_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      flag_rd |=> o_rdata == {30'h0, $past(err_reg), $past(unf_reg)})
    else $error("flag read data wrong");
  // main scenarios
  underflow_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) underflow);
  win_err_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) window_err);
  set_wr_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) set_wr);
  rd_clear_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) flag_rd && unf_reg);
  halt_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) halted && i_dbg_state);
endmodule

// [wwdt_rstc_model.sv]
// Purpose: reset controller model that answers the watchdog fault lines
// Assumes: fault outputs are levels in the system clock domain
// Notes: its own state ignores the reset it makes, as a real controller would
`timescale 1ns/1ns
module wwdt_rstc_model #(
  parameter int PULSE_LEN = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_fault_all,
  input wire logic i_fault_proc,
  output logic o_wd_rst_n
);
  int hold_reg = 0;
  initial o_wd_rst_n = 1'b1;
  // ==========================================
  // fault to reset pulse
  // either scope ends in a reset of the watchdog; the pulse outlasts the fault
  always @(posedge i_sys_clk) begin
    if (hold_reg > 0) begin
      hold_reg <= hold_reg - 1;
      o_wd_rst_n <= (hold_reg == 1);
    end else if (i_fault_all === 1'b1 || i_fault_proc === 1'b1) begin
      hold_reg <= PULSE_LEN;
      o_wd_rst_n <= 1'b0;
    end
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the windowed watchdog core
// Assumes: short dividers, one count step every eight system clocks
// Notes: settings take one write per reset, so scenarios reset between them
`timescale 1ns/1ns
`include "wwdt_defines.svh"
module tb_top;
  logic i_sys_clk = 1'b0;
  logic tb_rst_n = 1'b0;
  logic wd_rst_n;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_dbg_state = 1'b0;
  logic i_idle_mode = 1'b0;
  logic [31:0] o_rdata;
  logic o_irq, o_fault, o_fault_all_resets, o_fault_proc_only;
  logic [11:0] o_count;
  logic [31:0] rd_val;
  logic [11:0] held;
  logic [31:0] cmd_tbl [4] = '{32'h5A000001, 32'hA5000001, 32'hA5000000, 32'hA4000001};
  logic hit_tbl [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int errors = 0;
  int n_compared = 0;
  int n;
  always #10 i_sys_clk = ~i_sys_clk;
  wwdt_core #(.SLOW_DIV(2), .PRESCALE(4)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(tb_rst_n & wd_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_dbg_state(i_dbg_state),
    .i_idle_mode(i_idle_mode), .o_rdata(o_rdata), .o_irq(o_irq), .o_fault(o_fault),
    .o_fault_all_resets(o_fault_all_resets), .o_fault_proc_only(o_fault_proc_only),
    .o_count(o_count));
  wwdt_rstc_model u_rstc (.i_sys_clk(i_sys_clk), .i_fault_all(o_fault_all_resets),
    .i_fault_proc(o_fault_proc_only), .o_wd_rst_n(wd_rst_n));
  // ==========================================
  // shared tasks
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // a wait that ran out of its bound ends the run
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic do_reset();
    @(posedge i_sys_clk);
    tb_rst_n <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    tb_rst_n <= 1'b1;
    #1;
  endtask
  // ==========================================
  // main sequence
  initial begin
    do_reset();
    chk(o_count, 32'h0FFF);
    rd(`WWDT_OFS_SET, rd_val);
    chk(rd_val, `WWDT_SET_RESET);
    rd(`WWDT_OFS_FLAG, rd_val);
    chk(rd_val, 32'h0);
    chk({o_irq, o_fault}, 32'h0);
    // reload 0x020, window 0x030, irq enabled, both halt bits set
    wr(`WWDT_OFS_SET, 32'h30301020);
    chk(o_count, 32'h0020);
    wr(`WWDT_OFS_SET, 32'h00000100);
    rd(`WWDT_OFS_SET, rd_val);
    chk(rd_val, 32'h30301020);
    // key and restart bit combinations, counter below reload before each
    for (int r = 0; r < 4; r++) begin
      repeat (24) @(posedge i_sys_clk);
      wr(`WWDT_OFS_CMD, cmd_tbl[r]);
      chk(32'(o_count == 12'h020), 32'(hit_tbl[r]));
    end
    rd(`WWDT_OFS_FLAG, rd_val);
    chk(rd_val, 32'h0);
    // debug then idle halt freeze the count
    for (int k = 0; k < 2; k++) begin
      i_dbg_state <= (k == 0);
      i_idle_mode <= (k == 1);
      #1 held = o_count;
      repeat (40) @(posedge i_sys_clk);
      chk(o_count, held);
    end
    i_dbg_state <= 1'b0;
    i_idle_mode <= 1'b0;
    // underflow with reset enable clear: flag and irq, no fault
    for (n = 0; n < 600 && o_irq !== 1'b1; n++) @(posedge i_sys_clk);
    tmo(n, 600);
    repeat (12) @(posedge i_sys_clk);
    #1 chk({o_irq, o_fault}, 32'h2);
    rd(`WWDT_OFS_FLAG, rd_val);
    chk(rd_val, 32'h1);
    chk(o_irq, 1'b0);
    // disabled, scope processor only, window 0x010 below reload 0x040
    do_reset();
    wr(`WWDT_OFS_SET, 32'h0010E040); // no restart precedes this write
    repeat (40) @(posedge i_sys_clk);
    chk(o_count, 32'h0040);
    wr(`WWDT_OFS_CMD, 32'hA5000001);
    for (n = 0; n < 10 && o_fault !== 1'b1; n++) @(posedge i_sys_clk);
    tmo(n, 10);
    chk({o_fault_proc_only, o_fault_all_resets, o_irq}, 32'h4);
    for (n = 0; n < 20 && wd_rst_n !== 1'b1; n++) @(posedge i_sys_clk);
    for (n = 0; n < 20 && wd_rst_n !== 1'b1; n++) @(posedge i_sys_clk);
    tmo(n, 20);
    for (n = 0; n < 20 && wd_rst_n !== 1'b0 && o_fault === 1'b1; n++) @(posedge i_sys_clk);
    for (n = 0; n < 20 && wd_rst_n !== 1'b1; n++) @(posedge i_sys_clk);
    tmo(n, 20);
    #1 chk({o_fault, o_count}, 32'h0FFF);
    rd(`WWDT_OFS_SET, rd_val);
    chk(rd_val, `WWDT_SET_RESET);
    rd(`WWDT_OFS_FLAG, rd_val);
    chk(rd_val, 32'h0);
    close_out();
  end
endmodule
